// ===== rsc_pkg.sv
// Package for the reset source control block: register map, field layout, timing.
// Assumes a single 25 MHz clock and the plain register port of the core.
package rsc_pkg;

   localparam int unsigned CLK_HZ          = 25000000;
   localparam int unsigned PWRUP_DELAY_MS  = 64;
   localparam int unsigned PWRUP_CYCLES    = PWRUP_DELAY_MS * (CLK_HZ / 1000);
   localparam int unsigned PIN_FILT_CYCLES = 8;

   localparam logic [3:0] ADDR_BOR_CTRL    = 4'h0;
   localparam logic [3:0] ADDR_CAUSE       = 4'h1;

   localparam int unsigned BIT_SW_BOR_EN   = 7;
   localparam int unsigned BIT_FAST_START  = 6;
   localparam int unsigned BIT_BOR_READY   = 0;
   localparam logic        RST_SW_BOR_EN   = 1'b1;
   localparam logic        RST_FAST_START  = 1'b0;

   // Cause register fields, then time-out and power-down status bits
   localparam int unsigned BIT_STK_OVER    = 7;
   localparam int unsigned BIT_STK_UNDER   = 6;
   localparam int unsigned BIT_WDOG_N      = 4;
   localparam int unsigned BIT_EXTCLR_N    = 3;
   localparam int unsigned BIT_SOFT_N      = 2;
   localparam int unsigned BIT_POR_N       = 1;
   localparam int unsigned BIT_BOR_N       = 0;
   localparam int unsigned BIT_TIME_OUT    = 1;
   localparam int unsigned BIT_POWER_DOWN  = 0;

   localparam logic [1:0] BOR_MODE_OFF     = 2'h0;
   localparam logic [1:0] BOR_MODE_SW      = 2'h1;
   localparam logic [1:0] BOR_MODE_NOSLEEP = 2'h2;
   localparam logic [1:0] BOR_MODE_ON      = 2'h3;

   typedef struct packed {
      logic [1:0] brownout_mode_cfg;
      logic       low_power_brownout;
      logic       ext_clear_enable_cfg;
      logic       low_voltage_program_cfg;
      logic       stack_fault_reset_cfg;
      logic       powerup_delay_cfg_n;
   } rsc_cfg_s;

   typedef struct packed {
      logic       bor_trip;
      logic       lp_bor_trip;
      logic       bor_circuit_ready;
      logic       osc_start_done;
      logic       sleep;
      logic       wdog_timeout;
      logic       reset_instr;
      logic       stack_over;
      logic       stack_under;
      logic       prog_exit;
   } rsc_evt_s;

   typedef enum logic [1:0] {
      ST_POR  = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN  = 2'b10
   } rsc_state_e;

endpackage

// ===== rsc_reset_source_control.sv
// Reset source control: brown-out control register, reset combining, power-up delay.
// Assumes config word bits are static and event inputs are on ref_clk_i; the pin is async.
//
// How it works
// RULE_01: software enable drives detector only in mode 01
// RULE_02: fast start inert in always-on/off modes
// RULE_03: fast start forces band gap in modes 10/01
// RULE_04: bit 0 is read-only detector ready
// RULE_05: bits 5 to 1 read zero
// RULE_06: low-power monitor resets, sets brown-out flag
// RULE_07: low-power monitor enabled by its config bit
// RULE_08: generic brown-out is OR of both
// RULE_09: clear pin off only if both bits zero
// RULE_10: pin held low keeps device in reset
// RULE_11: pin filter ignores short pulses
// RULE_12: clear pin never driven by device
// RULE_13: disabled pin is input, software pull-up
// RULE_14: watchdog reset updates time-out, power-down flags
// RULE_15: reset instruction resets, clears its flag
// RULE_16: stack faults reset only when enabled
// RULE_17: programming exit acts as power-on
// RULE_18: power-up timer holds after power-on/brown-out
// RULE_19: 64 ms delay, enabled when bit clear
// RULE_20: four brown-out modes from config
// RULE_21: start waits timer, oscillator, pin release
// RULE_22: all sources merge into one held reset
`timescale 1ns/1ps
module rsc_reset_source_control #(
   parameter int unsigned PWRUP_CYCLES = rsc_pkg::PWRUP_CYCLES
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   input  wire rsc_pkg::rsc_cfg_s cfg_i,
   input  wire rsc_pkg::rsc_evt_s evt_i,
   input  wire logic [3:0]        addr_i,
   input  wire logic [7:0]        wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic [7:0]             rdata_o,
   input  wire logic              ext_clear_pin_i,
   output logic                   ext_clear_pin_o,
   output logic                   ext_clear_pin_oe_o,
   input  wire logic              sw_pullup_i,
   output logic                   pullup_en_o,
   output logic                   gp_in_o,
   output logic                   bor_enable_o,
   output logic                   bandgap_force_o,
   output logic                   generic_bor_o,
   output logic                   core_reset_o,
   output logic                   time_out_flag_o,
   output logic                   power_down_flag_o
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic       sw_brownout_enable_r;
   logic       brownout_fast_start_r;
   logic [2:0] pin_sync_r;
   logic [3:0] filt_cnt_r;
   logic       pin_low_r;
   logic       ext_clear_active;
   logic       lp_trip;
   logic       generic_bor;
   logic       por_event;
   logic       stk_rst;
   logic       sync_rst;
   logic [7:0] cause_r;
   logic       bor_src_r;
   logic [1:0] stat_r;
   logic [31:0] pwrup_cnt_r;
   logic       pwrup_busy;
   rsc_pkg::rsc_state_e state_r;
   rsc_pkg::rsc_state_e state_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Brown-out mode decode
   always_comb begin
      unique case (cfg_i.brownout_mode_cfg)                                      // RULE_20
         rsc_pkg::BOR_MODE_ON:      bor_enable_o = 1'b1;
         rsc_pkg::BOR_MODE_NOSLEEP: bor_enable_o = ~evt_i.sleep;
         rsc_pkg::BOR_MODE_SW:      bor_enable_o = sw_brownout_enable_r;         // RULE_01
         rsc_pkg::BOR_MODE_OFF:     bor_enable_o = 1'b0;
      endcase
   end

   assign bandgap_force_o = brownout_fast_start_r &&
                            (cfg_i.brownout_mode_cfg == rsc_pkg::BOR_MODE_NOSLEEP ||
                             cfg_i.brownout_mode_cfg == rsc_pkg::BOR_MODE_SW);   // RULE_02 RULE_03

   assign lp_trip       = cfg_i.low_power_brownout & evt_i.lp_bor_trip;          // RULE_07
   assign generic_bor   = lp_trip | (bor_enable_o & evt_i.bor_trip);             // RULE_08 RULE_06
   assign generic_bor_o = generic_bor;
   assign por_event     = evt_i.prog_exit;                                       // RULE_17
   assign stk_rst       = cfg_i.stack_fault_reset_cfg &
                          (evt_i.stack_over | evt_i.stack_under);                // RULE_16

   ////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sw_brownout_enable_r  <= rsc_pkg::RST_SW_BOR_EN;
         brownout_fast_start_r <= rsc_pkg::RST_FAST_START;
      end else if (wr_i && addr_i == rsc_pkg::ADDR_BOR_CTRL) begin
         sw_brownout_enable_r  <= wdata_i[rsc_pkg::BIT_SW_BOR_EN];              // RULE_01
         brownout_fast_start_r <= wdata_i[rsc_pkg::BIT_FAST_START];             // RULE_02
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register reads, one cycle latency
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         unique case (addr_i)
            rsc_pkg::ADDR_BOR_CTRL:
               rdata_o <= {sw_brownout_enable_r, brownout_fast_start_r, 5'h00,
                           evt_i.bor_circuit_ready};                             // RULE_04 RULE_05
            rsc_pkg::ADDR_CAUSE: rdata_o <= cause_r;
            default:             rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // External clear pin: synchroniser and pulse filter
   assign ext_clear_active   = cfg_i.ext_clear_enable_cfg | cfg_i.low_voltage_program_cfg; // RULE_09
   assign ext_clear_pin_o    = 1'b0;
   assign ext_clear_pin_oe_o = 1'b0;                                             // RULE_12
   assign pullup_en_o        = ext_clear_active ? 1'b1 : sw_pullup_i;            // RULE_13
   assign gp_in_o            = ext_clear_active ? 1'b0 : pin_sync_r[2];          // RULE_13

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_sync_r <= 3'h7;
      end else begin
         pin_sync_r <= {pin_sync_r[1:0], ext_clear_pin_i};
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         filt_cnt_r <= 4'h0;
         pin_low_r  <= 1'b0;
      end else if (pin_sync_r[2] != pin_sync_r[1]) begin
         filt_cnt_r <= 4'h0;
      end else if ((~pin_sync_r[2]) == pin_low_r) begin
         filt_cnt_r <= 4'h0;
      end else if (filt_cnt_r == 4'(rsc_pkg::PIN_FILT_CYCLES - 1)) begin
         filt_cnt_r <= 4'h0;
         pin_low_r  <= ~pin_sync_r[2];                                           // RULE_11
      end else begin
         filt_cnt_r <= filt_cnt_r + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power-up timer
   assign pwrup_busy = (pwrup_cnt_r != 32'h0);

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwrup_cnt_r <= 32'h0;
      end else if (state_r == rsc_pkg::ST_POR) begin
         pwrup_cnt_r <= cfg_i.powerup_delay_cfg_n ? 32'h0 : 32'(PWRUP_CYCLES);   // RULE_19 RULE_18
      end else if (pwrup_busy) begin
         pwrup_cnt_r <= pwrup_cnt_r - 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset sequencer
   assign sync_rst = (evt_i.wdog_timeout | evt_i.reset_instr | stk_rst) & (state_r == rsc_pkg::ST_RUN);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         rsc_pkg::ST_POR:  state_nxt = rsc_pkg::ST_WAIT;
         rsc_pkg::ST_WAIT: if (!pwrup_busy && evt_i.osc_start_done &&
                               !(ext_clear_active && pin_low_r)) state_nxt = rsc_pkg::ST_RUN; // RULE_21
         rsc_pkg::ST_RUN:  if (sync_rst || (ext_clear_active && pin_low_r)) state_nxt = rsc_pkg::ST_WAIT; // RULE_10
         default:          state_nxt = rsc_pkg::ST_POR;
      endcase
      if (generic_bor || por_event) begin
         state_nxt = rsc_pkg::ST_POR;                                            // RULE_18
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= rsc_pkg::ST_POR;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign core_reset_o = (state_r != rsc_pkg::ST_RUN);                           // RULE_22

   ////////////////////////////////////////////////////////////////////////
   // Marks a power-on pass entered from brown-out
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bor_src_r <= 1'b0;
      end else if (generic_bor) begin
         bor_src_r <= 1'b1;
      end else if (state_r != rsc_pkg::ST_POR) begin
         bor_src_r <= 1'b0;
      end
   end

   // Reset cause flags, active low except stack faults
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cause_r <= 8'h1C;
      end else if (por_event || (state_r == rsc_pkg::ST_POR && !generic_bor && !bor_src_r)) begin
         cause_r <= 8'h1C;                                                       // RULE_17
         cause_r[rsc_pkg::BIT_BOR_N] <= 1'b1;
      end else if (generic_bor) begin
         cause_r <= 8'h1D;
         cause_r[rsc_pkg::BIT_BOR_N] <= 1'b0;                                    // RULE_06
      end else begin
         if (wr_i && addr_i == rsc_pkg::ADDR_CAUSE)
            cause_r <= wdata_i & 8'hDF;
         if (state_r == rsc_pkg::ST_RUN && evt_i.wdog_timeout)
            cause_r[rsc_pkg::BIT_WDOG_N] <= 1'b0;
         if (state_r == rsc_pkg::ST_RUN && evt_i.reset_instr)
            cause_r[rsc_pkg::BIT_SOFT_N] <= 1'b0;                                // RULE_15
         if (state_r == rsc_pkg::ST_RUN && stk_rst && evt_i.stack_over)
            cause_r[rsc_pkg::BIT_STK_OVER] <= 1'b1;                              // RULE_16
         if (state_r == rsc_pkg::ST_RUN && stk_rst && evt_i.stack_under)
            cause_r[rsc_pkg::BIT_STK_UNDER] <= 1'b1;
         if (state_r == rsc_pkg::ST_RUN && ext_clear_active && pin_low_r)
            cause_r[rsc_pkg::BIT_EXTCLR_N] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Time-out and power-down status
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stat_r <= 2'h3;
      end else if (state_r == rsc_pkg::ST_POR) begin
         stat_r <= 2'h3;
      end else if (state_r == rsc_pkg::ST_RUN && evt_i.wdog_timeout) begin
         stat_r[rsc_pkg::BIT_TIME_OUT]   <= 1'b0;                                // RULE_14
         stat_r[rsc_pkg::BIT_POWER_DOWN] <= ~evt_i.sleep;
      end
   end

   assign time_out_flag_o   = stat_r[rsc_pkg::BIT_TIME_OUT];
   assign power_down_flag_o = stat_r[rsc_pkg::BIT_POWER_DOWN];

endmodule // rsc_reset_source_control

// ===== rsc_properties.sv
// Port checker for reset source control.
// Assumes a bind onto rsc_reset_source_control, one clock domain.
`timescale 1ns/1ps
module rsc_properties (
   input wire logic              ref_clk_i,
   input wire logic              rst_n_i,
   input wire rsc_pkg::rsc_cfg_s cfg_i,
   input wire rsc_pkg::rsc_evt_s evt_i,
   input wire logic [3:0]        addr_i,
   input wire logic              rd_i,
   input wire logic [7:0]        rdata_o,
   input wire logic              ext_clear_pin_i,
   input wire logic              ext_clear_pin_o,
   input wire logic              ext_clear_pin_oe_o,
   input wire logic              bor_enable_o,
   input wire logic              bandgap_force_o,
   input wire logic              generic_bor_o,
   input wire logic              core_reset_o,
   input wire logic              time_out_flag_o
);
   wire        clr_on = cfg_i.ext_clear_enable_cfg | cfg_i.low_voltage_program_cfg;
   logic [3:0] low_cnt_r;
   ////////////////////////////////////////////////////////////////////////////////
   // Cycles the enabled pin has been low
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         low_cnt_r <= 4'h0;
      else if (!clr_on || ext_clear_pin_i)
         low_cnt_r <= 4'h0;
      else if (low_cnt_r != 4'hF)
         low_cnt_r <= low_cnt_r + 4'h1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_pin_never_driven: assert property (!ext_clear_pin_oe_o && !ext_clear_pin_o)
      else $error("clear pin driven");
   a_bor_mode_en: assert property (cfg_i.brownout_mode_cfg != rsc_pkg::BOR_MODE_SW |->
      bor_enable_o == (cfg_i.brownout_mode_cfg == rsc_pkg::BOR_MODE_ON ||
      (cfg_i.brownout_mode_cfg == rsc_pkg::BOR_MODE_NOSLEEP && !evt_i.sleep))) else $error("bad detector enable");
   a_fast_inert: assert property (cfg_i.brownout_mode_cfg[1] == cfg_i.brownout_mode_cfg[0] |->
      !bandgap_force_o) else $error("fast start active");
   a_generic_or: assert property (generic_bor_o ==
      ((evt_i.bor_trip && bor_enable_o) || (evt_i.lp_bor_trip && cfg_i.low_power_brownout)))
      else $error("bad generic brown-out");
   a_bor_holds: assert property (generic_bor_o |=> core_reset_o ##1 core_reset_o)
      else $error("brown-out not held");
   a_ctrl_read: assert property ($past(rd_i) && $past(addr_i) == rsc_pkg::ADDR_BOR_CTRL |->
      rdata_o[5:1] == 5'h00 && rdata_o[0] == $past(evt_i.bor_circuit_ready)) else $error("bad control read");
   a_wdog_reset: assert property (evt_i.wdog_timeout && !core_reset_o |=> core_reset_o && !time_out_flag_o)
      else $error("watchdog reset missed");
   a_sync_reset: assert property (evt_i.reset_instr || (cfg_i.stack_fault_reset_cfg &&
      (evt_i.stack_over || evt_i.stack_under)) |=> core_reset_o) else $error("sync reset missed");
   a_pin_hold: assert property (low_cnt_r == 4'hF |-> core_reset_o)
      else $error("pin low not in reset");
   a_prog_exit: assert property ($rose(evt_i.prog_exit) |=> core_reset_o [*2])
      else $error("programming exit not reset");
endmodule // rsc_properties

// ===== tb_reset_source_control.sv
// Testbench for reset source control: registers, reset sources, pin filter.
// Assumes rsc_pkg and rsc_properties are compiled first.
`timescale 1ns/1ps
module tb_reset_source_control;
   logic              ref_clk_i = 1'b0;
   logic              rst_n_i   = 1'b0;
   rsc_pkg::rsc_cfg_s cfg       = '0;
   rsc_pkg::rsc_evt_s evt       = 10'h040;
   logic [3:0]        addr      = 4'h0;
   logic [7:0]        wdata     = 8'h00;
   logic              wr        = 1'b0;
   logic              rd        = 1'b0;
   logic              rd_q      = 1'b0;
   logic              pin       = 1'b1;
   logic              pu        = 1'b0;
   logic [7:0]        rdata, d, r;
   logic              pu_o, gpi, bor_en, bgf, gbor, crst, tof;
   logic [7:0]        exp_q[$];
   int                err_total = 0;
   int                tests_run = 0;
   int                cyc       = 0;
   int                n;
   int                ev[6]     = '{9, 8, 4, 2, 1, 0};
   rsc_reset_source_control #(.PWRUP_CYCLES(20)) DUT (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg), .evt_i(evt), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_clear_pin_i(pin), .ext_clear_pin_o(), .ext_clear_pin_oe_o(),
      .sw_pullup_i(pu), .pullup_en_o(pu_o), .gp_in_o(gpi), .bor_enable_o(bor_en), .bandgap_force_o(bgf),
      .generic_bor_o(gbor), .core_reset_o(crst), .time_out_flag_o(tof), .power_down_flag_o()
   );
   ////////////////////////////////////////////////////////////////////////////////
   always #20 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) rd_q <= rd;
   always @(negedge ref_clk_i) if (rd_q) check(rdata, exp_q.pop_front());
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      tests_run++;
      if (seen !== want) begin
         err_total++;
         $display("unexpected at %0t: got %h exp %h", $time, seen, want);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      if (!w) exp_q.push_back(v);
      addr  <= a;
      wdata <= v;
      wr    <= w;
      rd    <= !w;
      @(posedge ref_clk_i);
      wr    <= 1'b0;
      rd    <= 1'b0;
   endtask
   task automatic wait_run;
      n = 0;
      while (crst !== 1'b0 && n < 200) begin
         @(posedge ref_clk_i);
         n++;
      end
   endtask
   task automatic pulse(input int b);
      @(posedge ref_clk_i);
      evt[b] <= 1'b1;
      @(posedge ref_clk_i);
      evt[b] <= 1'b0;
      @(negedge ref_clk_i);
      check(crst, 1);
      wait_run();
      check(crst, 0);
   endtask
   task automatic pin_low(input int k);
      @(posedge ref_clk_i);
      pin <= 1'b0;
      repeat (k) @(posedge ref_clk_i);
      pin <= 1'b1;
      repeat (14) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      r = 8'($urandom(960));
      repeat (20) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      evt.bor_circuit_ready <= r[0];
      wait_run();
      check(n >= 20, 1);
      bus(0, rsc_pkg::ADDR_BOR_CTRL, {7'h40, r[0]});
      repeat (4) begin
         d = 8'($urandom);
         bus(1, rsc_pkg::ADDR_BOR_CTRL, d);
         bus(0, rsc_pkg::ADDR_BOR_CTRL, {d[7:6], 5'h00, r[0]});
      end
      bus(0, 4'h7, 8'h00);
      for (int m = 0; m < 4; m++) for (int s = 0; s < 4; s++) begin
         cfg.brownout_mode_cfg <= 2'(m);
         evt.sleep <= s[0];
         bus(1, rsc_pkg::ADDR_BOR_CTRL, {s[1:0], 6'h00});
         @(negedge ref_clk_i);
         check(bor_en, m == 3 || (m == 2 && !s[0]) || (m == 1 && s[1]));
         check(bgf, (m == 1 || m == 2) && s[0]);
      end
      bus(1, rsc_pkg::ADDR_CAUSE, 8'h04);
      pulse(3);
      bus(0, rsc_pkg::ADDR_CAUSE, 8'h00);
      cfg.stack_fault_reset_cfg <= 1'b1;
      cfg.low_power_brownout    <= 1'b1;
      foreach (ev[i]) begin
         pulse(ev[i]);
         if (ev[i] == 4) check(tof, 0);
         if (ev[i] > 7 || ev[i] == 0) check(n >= 18, 1);
         if (ev[i] > 7 || ev[i] == 0) bus(0, rsc_pkg::ADDR_CAUSE, (ev[i] != 0) ? 8'h1C : 8'h1D);
      end
      cfg <= '0;
      @(posedge ref_clk_i);
      evt <= evt | 10'h106;
      pu  <= r[1];
      repeat (2) @(posedge ref_clk_i);
      evt <= evt & ~10'h106;
      @(negedge ref_clk_i);
      check(gbor, 0);
      check(crst, 0);
      pin_low(16);
      check(crst, 0);
      check(pu_o, r[1]);
      check(gpi, 1);
      cfg.low_voltage_program_cfg <= 1'b1;
      pin_low(3);
      check(crst, 0);
      check(gpi, 0);
      cfg.low_voltage_program_cfg <= 1'b0;
      cfg.ext_clear_enable_cfg    <= 1'b1;
      @(posedge ref_clk_i);
      pin <= 1'b0;
      repeat (16) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check(crst, 1);
      check(pu_o, 1);
      @(posedge ref_clk_i);
      pin <= 1'b1;
      wait_run();
      check(crst, 0);
      cfg.powerup_delay_cfg_n <= 1'b1;
      rst_n_i <= 1'b0;
      @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      wait_run();
      check(n < 10, 1);
      print_verdict();
   end
endmodule // tb_reset_source_control

bind rsc_reset_source_control rsc_properties u_props (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg_i), .evt_i(evt_i), .addr_i(addr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .ext_clear_pin_i(ext_clear_pin_i), .ext_clear_pin_o(ext_clear_pin_o),
   .ext_clear_pin_oe_o(ext_clear_pin_oe_o), .bor_enable_o(bor_enable_o), .bandgap_force_o(bandgap_force_o),
   .generic_bor_o(generic_bor_o), .core_reset_o(core_reset_o), .time_out_flag_o(time_out_flag_o)
);
